/* File: rtl/mdp_pkg.sv */
package mdp_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_FAULT = 8'h08;
	localparam logic [7:0] ADDR_HALL = 8'h0c;
	localparam int CTRL_HOST_RUN = 0;
	localparam int CTRL_HOST_SEL = 1;
	localparam int CTRL_FAULT_RST = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam int FLT_PHASE = 0;
	localparam int FLT_OVERV = 1;
	localparam int FLT_UNDERV = 2;
	localparam int FLT_SPEED = 3;
	localparam int FLT_EXT = 4;
	localparam int FLT_W = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int DEAD_TIME_NS = 2000;
	localparam int CARRIER_PERIOD_US = 50;
	localparam int SPEED_PERIOD_US = 500;
	localparam int DEAD_CYC = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CARRIER_CYC = CARRIER_PERIOD_US * 1000000 / CLK_PERIOD_PS;
	localparam int SPEED_CYC = SPEED_PERIOD_US * 1000000 / CLK_PERIOD_PS;
	// ==========================================================
	// Protection limits, phase and bus limits converted to converter codes, speed limit kept in rpm
	localparam int ADC_W = 12;
	localparam int ADC_FULL = 4095;
	localparam int ADC_MID = 2048;
	localparam int PHASE_LIMIT_MA = 3540;
	localparam int PHASE_FULL_MA = 8250;
	localparam int VBUS_OVER_MV = 60000;
	localparam int VBUS_UNDER_MV = 8000;
	localparam int VBUS_FULL_MV = 73260;
	localparam int SPEED_LIMIT_RPM = 4500;
	localparam int PHASE_SPAN = ADC_MID * PHASE_LIMIT_MA / PHASE_FULL_MA;
	localparam logic [11:0] PHASE_HI_CODE = 12'(ADC_MID + PHASE_SPAN);
	localparam logic [11:0] PHASE_LO_CODE = 12'(ADC_MID - PHASE_SPAN);
	localparam logic [11:0] VBUS_OVER_CODE = 12'(ADC_FULL * VBUS_OVER_MV / VBUS_FULL_MV);
	localparam logic [11:0] VBUS_UNDER_CODE = 12'(ADC_FULL * VBUS_UNDER_MV / VBUS_FULL_MV);
	localparam logic [15:0] SPEED_LIMIT_CODE = 16'(SPEED_LIMIT_RPM);
	// ==========================================================
	// Event levels
	localparam logic [3:0] LEVEL_FAULT = 4'h0;
	localparam logic [3:0] LEVEL_CURRENT = 4'h5;
	localparam logic [3:0] LEVEL_SPEED = 4'ha;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		MDP_INACTIVE = 2'b00,
		MDP_ACTIVE = 2'b01,
		MDP_ERROR = 2'b10
	} mdp_mode_t;

	typedef struct packed {
		logic [11:0] phase_u;
		logic [11:0] phase_v;
		logic [11:0] phase_w;
		logic [11:0] vbus;
		logic [15:0] speed_rpm;
	} mdp_meas_t;

	typedef struct packed {
		logic fault;
		logic current;
		logic speed;
	} mdp_task_t;
endpackage : mdp_pkg

/* File: rtl/mdp_leg.sv */
`timescale 1ns/1ps
`default_nettype none
module mdp_leg
	import mdp_pkg::*;
#(
	parameter int DEAD = DEAD_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic pwm_ref,
	output logic gate_hi,
	output logic gate_lo
);
	localparam int CW = $clog2(DEAD + 1);
	logic [CW-1:0] dead_cnt;
	logic applied;

	// ==========================================================
	// Dead time: both switches stay off for DEAD+1 cycles after any change.
	always_ff @(posedge aclk) begin
		if (!aresetn || !enable) begin
			dead_cnt <= CW'(DEAD);
			applied <= 1'b0;
		end else if (pwm_ref != applied) begin
			dead_cnt <= CW'(DEAD);
			applied <= pwm_ref;
		end else if (dead_cnt != '0) begin
			dead_cnt <= dead_cnt - 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !enable) begin
			gate_hi <= 1'b0;
			gate_lo <= 1'b0;
		end else if (pwm_ref != applied || dead_cnt != '0) begin
			gate_hi <= 1'b0;
			gate_lo <= 1'b0;
		end else begin
			gate_hi <= applied;
			gate_lo <= !applied;
		end
	end

	chk_dead_gap: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(gate_hi) |-> !gate_lo [*8]) else $error("Low switch turned on inside dead time.");
endmodule : mdp_leg
`default_nettype wire

/* File: rtl/mdp_scheduler.sv */
// Function
// - Any fault disables all six gate outputs.
// - Trip when phase current exceeds 3.54 A.
// - Trip when bus voltage exceeds 60 V.
// - Trip when bus voltage below 8 V.
// - Trip when speed exceeds 4500 rpm.
// - Low external overcurrent input means fault.
// - External overcurrent floats all outputs on the next clock edge.
// - Run from switch level or host command.
// - Speed task every 500 us, level 10.
// - Current task on conversion done, level 5.
// - Overcurrent disable event has level 0.
// - Sample hall inputs every 50 us carrier.
// - Bus voltage fault stops modulation output.
`timescale 1ns/1ps
`default_nettype none
module mdp_scheduler
	import mdp_pkg::*;
#(
	parameter int SPEED_TICKS = SPEED_CYC,
	parameter int CARRIER_TICKS = CARRIER_CYC,
	parameter int DEAD = DEAD_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic run_request_switch,
	input wire logic overcurrent_n,
	input wire logic conversion_done_event,
	input wire mdp_meas_t meas,
	input wire logic [2:0] hall,
	input wire logic [2:0] pwm_ref,
	output logic [2:0] gate_hi,
	output logic [2:0] gate_lo,
	output logic [5:0] gate_oe,
	output mdp_task_t task_start,
	output logic [3:0] task_level,
	output logic speed_tick_event,
	output logic hall_change,
	output mdp_mode_t mode
);
	if (SPEED_TICKS < 2 || CARRIER_TICKS < 2 || DEAD < 1) begin : g_bad
		$error("Tick counts too small.");
	end

	// ==========================================================
	// Register bus
	logic [31:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aw_held;
	logic w_held;
	logic [2:0] ctrl;
	logic fault_rst_req;
	logic [FLT_W-1:0] fault_cause;
	logic [2:0] hall_q;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_FAULT) || (a == ADDR_HALL);
	endfunction : mapped

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 32'h0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !(s_axi_awvalid && s_axi_awready) && !aw_held && !(s_axi_bvalid && !s_axi_bready);
			s_axi_wready <= !(s_axi_wvalid && s_axi_wready) && !w_held && !(s_axi_bvalid && !s_axi_bready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= {24'h0, s_axi_awaddr};
			end else if (aw_held && w_held) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (aw_held && w_held) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (aw_held && w_held) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(aw_addr_q[7:0]) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RESET;
			fault_rst_req <= 1'b0;
		end else begin
			fault_rst_req <= 1'b0;
			if (aw_held && w_held && aw_addr_q[7:0] == ADDR_CTRL && w_strb_q[0]) begin
				ctrl[CTRL_HOST_RUN] <= w_data_q[CTRL_HOST_RUN];
				ctrl[CTRL_HOST_SEL] <= w_data_q[CTRL_HOST_SEL];
				fault_rst_req <= w_data_q[CTRL_FAULT_RST];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else if (s_axi_arvalid && !s_axi_arready) begin
			s_axi_arready <= 1'b1;
		end else if (s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				ADDR_CTRL: s_axi_rdata <= {29'h0, 1'b0, ctrl[1:0]};
				ADDR_STATUS: s_axi_rdata <= {27'h0, overcurrent_n, run_request_switch, gate_oe[0], mode};
				ADDR_FAULT: s_axi_rdata <= {27'h0, fault_cause};
				ADDR_HALL: s_axi_rdata <= {29'h0, hall_q};
				default: s_axi_rdata <= 32'h0;
			endcase
		end
	end

	// ==========================================================
	// Periodic ticks
	logic [$clog2(SPEED_TICKS)-1:0] speed_cnt;
	logic [$clog2(CARRIER_TICKS)-1:0] carrier_cnt;
	logic carrier_tick;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			speed_cnt <= '0;
			speed_tick_event <= 1'b0;
		end else begin
			speed_tick_event <= (speed_cnt == $bits(speed_cnt)'(SPEED_TICKS - 1));
			speed_cnt <= (speed_cnt == $bits(speed_cnt)'(SPEED_TICKS - 1)) ? '0 : speed_cnt + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			carrier_cnt <= '0;
			carrier_tick <= 1'b0;
		end else begin
			carrier_tick <= (carrier_cnt == $bits(carrier_cnt)'(CARRIER_TICKS - 1));
			carrier_cnt <= (carrier_cnt == $bits(carrier_cnt)'(CARRIER_TICKS - 1)) ? '0 : carrier_cnt + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hall_q <= 3'h0;
			hall_change <= 1'b0;
		end else begin
			hall_change <= 1'b0;
			if (carrier_tick) begin
				hall_q <= hall;
				// The cleared sample after reset is no pattern, so the first sample is not a change.
				hall_change <= (hall != hall_q) && (hall_q != 3'h0);
			end
		end
	end

	// ==========================================================
	// Protection checks: measurements once per current control period, external input every cycle
	logic [FLT_W-1:0] trip;
	logic ext_fault;

	function automatic logic phase_over(input logic [11:0] c);
		phase_over = (c > PHASE_HI_CODE) || (c < PHASE_LO_CODE);
	endfunction : phase_over

	assign ext_fault = !overcurrent_n;

	always_comb begin
		trip = '0;
		if (conversion_done_event) begin
			trip[FLT_PHASE] = phase_over(meas.phase_u) || phase_over(meas.phase_v) || phase_over(meas.phase_w);
			trip[FLT_OVERV] = meas.vbus > VBUS_OVER_CODE;
			trip[FLT_UNDERV] = meas.vbus < VBUS_UNDER_CODE;
			trip[FLT_SPEED] = meas.speed_rpm > SPEED_LIMIT_CODE;
		end
		trip[FLT_EXT] = ext_fault;
	end

	// A new trip in the reset cycle keeps its cause bit set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_cause <= '0;
		end else begin
			fault_cause <= (fault_rst_req ? '0 : fault_cause) | trip;
		end
	end

	// ==========================================================
	// System mode
	mdp_mode_t next_mode;
	logic run_req;

	assign run_req = ctrl[CTRL_HOST_SEL] ? ctrl[CTRL_HOST_RUN] : run_request_switch;

	always_comb begin
		next_mode = mode;
		case (mode)
			MDP_INACTIVE: begin
				if (trip != '0) begin
					next_mode = MDP_ERROR;
				end else if (run_req) begin
					next_mode = MDP_ACTIVE;
				end
			end
			MDP_ACTIVE: begin
				if (trip != '0) begin
					next_mode = MDP_ERROR;
				end else if (!run_req) begin
					next_mode = MDP_INACTIVE;
				end
			end
			MDP_ERROR: begin
				if (fault_rst_req && trip == '0) begin
					next_mode = MDP_INACTIVE;
				end
			end
			default: next_mode = MDP_ERROR;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode <= MDP_INACTIVE;
		end else begin
			mode <= next_mode;
		end
	end

	// ==========================================================
	// Gate outputs
	logic drive;

	assign drive = (mode == MDP_ACTIVE) && (next_mode == MDP_ACTIVE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_oe <= 6'h0;
		end else begin
			gate_oe <= (ext_fault || next_mode != MDP_ACTIVE) ? 6'h0 : 6'h3f;
		end
	end

	for (genvar gi = 0; gi < 3; gi++) begin : g_leg
		mdp_leg #(
			.DEAD(DEAD)
		) u_leg (
			.aclk(aclk),
			.aresetn(aresetn),
			.enable(drive),
			.pwm_ref(pwm_ref[gi]),
			.gate_hi(gate_hi[gi]),
			.gate_lo(gate_lo[gi])
		);
	end

	// ==========================================================
	// Event dispatch by fixed level
	mdp_task_t pend;
	logic overcurrent_n_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend <= '0;
			task_start <= '0;
			task_level <= LEVEL_SPEED;
		end else begin
			task_start <= '0;
			if (pend.fault) begin
				task_start.fault <= 1'b1;
				task_level <= LEVEL_FAULT;
			end else if (pend.current) begin
				task_start.current <= 1'b1;
				task_level <= LEVEL_CURRENT;
			end else if (pend.speed) begin
				task_start.speed <= 1'b1;
				task_level <= LEVEL_SPEED;
			end
			pend.fault <= ext_fault && overcurrent_n_q;
			pend.current <= (pend.current && pend.fault) | conversion_done_event;
			pend.speed <= (pend.speed && (pend.fault || pend.current)) | speed_tick_event;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overcurrent_n_q <= 1'b1;
		end else begin
			overcurrent_n_q <= overcurrent_n;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_ext_low;
		!overcurrent_n;
	endsequence

	sequence s_outputs_off;
		gate_oe == 6'h0 ##1 gate_hi == 3'h0 && gate_lo == 3'h0;
	endsequence

	chk_ext_float: assert property (s_ext_low |=> s_outputs_off) else $error("Outputs not floated.");
	chk_ext_error: assert property (s_ext_low |=> mode == MDP_ERROR) else $error("External fault not latched.");
	chk_trip_off: assert property (trip != '0 |=> gate_oe == 6'h0) else $error("Trip left outputs on.");
	chk_bus_stop: assert property (conversion_done_event && (meas.vbus > VBUS_OVER_CODE || meas.vbus < VBUS_UNDER_CODE)
		|=> mode == MDP_ERROR ##1 gate_hi == 3'h0) else $error("Bus fault kept modulating.");
	chk_phase_trip: assert property (conversion_done_event && phase_over(meas.phase_v) |=> fault_cause[FLT_PHASE])
		else $error("Phase fault missed.");
	chk_speed_trip: assert property (conversion_done_event && meas.speed_rpm > SPEED_LIMIT_CODE |=> fault_cause[FLT_SPEED])
		else $error("Overspeed missed.");
	chk_error_hold: assert property (mode == MDP_ERROR && !fault_rst_req |=> mode == MDP_ERROR)
		else $error("Error left without reset.");
	chk_switch_run: assert property (mode == MDP_INACTIVE && !ctrl[CTRL_HOST_SEL] && run_request_switch && trip == '0
		|=> mode == MDP_ACTIVE) else $error("Switch did not start.");
	chk_speed_tick: assert property ($rose(speed_tick_event) |=> !speed_tick_event) else $error("Tick not a pulse.");
	chk_current_first: assert property (pend.current && pend.speed && !pend.fault |=> task_start.current && !task_start.speed)
		else $error("Speed ran before current.");
	chk_fault_first: assert property (pend.fault |=> task_start.fault && task_level == LEVEL_FAULT)
		else $error("Fault event not first.");
	chk_hall_sample: assert property (carrier_tick |=> hall_q == $past(hall)) else $error("Hall not sampled.");
endmodule : mdp_scheduler
`default_nettype wire

/* File: testbench/mdp_power_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module mdp_power_stage #(
	parameter int STEP = 37
) (
	input wire logic aclk,
	input wire logic [2:0] gate_hi,
	input wire logic [2:0] gate_lo,
	input wire logic trip_cmd,
	input wire logic spin,
	output logic overcurrent_n,
	output logic [2:0] hall
);
	// ==========================================================
	// Hall pattern of a rotor turning forward, one step every STEP cycles.
	int cnt = 0;
	logic [2:0] pat = 3'h1;
	logic shoot = 1'b0;
	always @(posedge aclk) begin
		if (spin && cnt == STEP - 1) begin
			case (pat)
				3'h1: pat <= 3'h5;
				3'h5: pat <= 3'h4;
				3'h4: pat <= 3'h6;
				3'h6: pat <= 3'h2;
				3'h2: pat <= 3'h3;
				default: pat <= 3'h1;
			endcase
		end
		cnt <= (cnt == STEP - 1) ? 0 : cnt + 1;
		shoot <= |(gate_hi & gate_lo);
	end
	assign hall = pat;
	// A shoot-through in any leg trips the comparator as a real stage would.
	assign overcurrent_n = !(trip_cmd || shoot);
endmodule : mdp_power_stage
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mdp_pkg::*;
	localparam int SPD = 50;
	localparam int DT = 10;
	localparam mdp_meas_t NOM = {12'h800, 12'h800, 12'h800, 12'h6d0, 16'h03e8};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic sw = 1'b0, cdone = 1'b0, trip = 1'b0, spin = 1'b1, oc_n, tick, hchg;
	logic [2:0] pwm = 3'h0;
	logic [2:0] hall, gate_hi, gate_lo;
	logic [5:0] gate_oe;
	logic [3:0] task_level;
	logic [3:0] pri;
	mdp_meas_t meas = NOM;
	mdp_meas_t m;
	mdp_task_t task_start;
	mdp_mode_t mode;
	logic [1:0] q[$];
	int fails = 0, checked = 0, cycles = 0, gap = 0, ticks = 0, hall_seen = 0, n;
	int fb [10] = '{FLT_PHASE, FLT_PHASE, -1, -1, FLT_OVERV, FLT_UNDERV, -1, -1, FLT_SPEED, -1};

	always #2.5 aclk = ~aclk;

	mdp_scheduler #(.SPEED_TICKS(SPD), .CARRIER_TICKS(20), .DEAD(DT)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .run_request_switch(sw), .overcurrent_n(oc_n), .conversion_done_event(cdone),
		.meas(meas), .hall(hall), .pwm_ref(pwm), .gate_hi(gate_hi), .gate_lo(gate_lo), .gate_oe(gate_oe),
		.task_start(task_start), .task_level(task_level), .speed_tick_event(tick), .hall_change(hchg),
		.mode(mode));

	mdp_power_stage stage (.aclk(aclk), .gate_hi(gate_hi), .gate_lo(gate_lo), .trip_cmd(trip), .spin(spin),
		.overcurrent_n(oc_n), .hall(hall));

	// ==========================================================
	// Checking and closing
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic close_out();
		$display("Checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			close_out();
		end
	end

	// ==========================================================
	// Event monitor
	always @(negedge aclk) begin
		if (!aresetn) begin
			gap = 0;
		end else begin
			check("one task", 32'h1, 32'($countones(task_start) <= 1));
			if (task_start.fault) check("fault lvl", {28'h0, LEVEL_FAULT}, {28'h0, task_level});
			if (task_start.current) check("cur lvl", {28'h0, LEVEL_CURRENT}, {28'h0, task_level});
			if (task_start.speed) check("spd lvl", {28'h0, LEVEL_SPEED}, {28'h0, task_level});
			if (|task_start) q.push_back(task_start.fault ? 2'h0 : task_start.current ? 2'h1 : 2'h2);
			if (hchg === 1'b1) hall_seen++;
			if (tick === 1'b1) begin
				ticks++;
				if (gap != 0) check("tick gap", SPD, gap);
				gap = 1;
			end else if (gap != 0) begin
				gap++;
			end
		end
	end

	// ==========================================================
	// Register bus master
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_hit, w_hit, b_hit;
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			aw_hit = awvalid && awready;
			w_hit = wvalid && wready;
			b_hit = bvalid;
			r = bresp;
			@(posedge aclk);
			if (aw_hit) awvalid <= 1'b0;
			if (w_hit) wvalid <= 1'b0;
		end while (!b_hit);
		bready <= 1'b0;
		check("bresp", {30'h0, er}, {30'h0, r});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input logic [1:0] er);
		logic ar_hit, r_hit;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ar_hit = arvalid && arready;
			r_hit = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar_hit) arvalid <= 1'b0;
		end while (!r_hit);
		rready <= 1'b0;
		check("rdata", exp, d & mask);
		check("rresp", {30'h0, er}, {30'h0, r});
	endtask : rd

	task automatic wait_mode(input mdp_mode_t w);
		for (int i = 0; i < 40 && mode !== w; i++) @(negedge aclk);
		check("mode", {30'h0, w}, {30'h0, mode});
	endtask : wait_mode

	// ==========================================================
	// Scenarios
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check("mode", {30'h0, MDP_INACTIVE}, {30'h0, mode});
		check("level", {28'h0, LEVEL_SPEED}, {28'h0, task_level});
		check("oe", 32'h0, {26'h0, gate_oe});
		rd(8'h10, 32'hffffffff, 32'h0, RESP_SLVERR);
		wr(8'h14, 32'h1, RESP_SLVERR);
		@(posedge aclk);
		sw <= 1'b1;
		wait_mode(MDP_ACTIVE);
		check("oe", 32'h3f, {26'h0, gate_oe});
		rd(ADDR_STATUS, 32'h1f, 32'h1d, RESP_OKAY);
		@(posedge aclk);
		sw <= 1'b0;
		wait_mode(MDP_INACTIVE);
		wr(ADDR_CTRL, 32'h2, RESP_OKAY);
		@(posedge aclk);
		sw <= 1'b1;
		repeat (10) @(negedge aclk);
		check("mode", {30'h0, MDP_INACTIVE}, {30'h0, mode});
		@(posedge aclk);
		sw <= 1'b0;
		wr(ADDR_CTRL, 32'h3, RESP_OKAY);
		wait_mode(MDP_ACTIVE);
		repeat (DT + 5) @(negedge aclk);
		check("lo gates", 32'h7, {29'h0, gate_lo});
		@(posedge aclk);
		pwm <= 3'h1;
		n = 0;
		for (int i = 0; i < 40 && gate_hi[0] !== 1'b1; i++) begin
			@(negedge aclk);
			n += (gate_hi[0] === 1'b0 && gate_lo[0] === 1'b0);
		end
		check("dead gap", 32'h1, 32'(n >= DT && n <= DT + 2));
		for (int k = 0; k < 10; k++) begin
			m = NOM;
			case (k)
				0: m.phase_u = 12'hb6f;
				1: m.phase_v = 12'h491;
				2: m.phase_w = 12'hb6e;
				3: m.phase_u = 12'h492;
				4: m.vbus = 12'hd1a;
				5: m.vbus = 12'h1be;
				6: m.vbus = 12'hd19;
				7: m.vbus = 12'h1bf;
				8: m.speed_rpm = 16'h1195;
				default: m.speed_rpm = 16'h1194;
			endcase
			wr(ADDR_CTRL, 32'h3, RESP_OKAY);
			wait_mode(MDP_ACTIVE);
			@(posedge aclk);
			meas <= m;
			cdone <= 1'b1;
			@(posedge aclk);
			meas <= NOM;
			cdone <= 1'b0;
			@(negedge aclk);
			if (fb[k] < 0) begin
				check("mode", {30'h0, MDP_ACTIVE}, {30'h0, mode});
			end else begin
				check("mode", {30'h0, MDP_ERROR}, {30'h0, mode});
				check("oe", 32'h0, {26'h0, gate_oe});
				@(negedge aclk);
				check("gates", 32'h0, {26'h0, gate_hi, gate_lo});
				rd(ADDR_FAULT, 32'h1f, 32'h1 << fb[k], RESP_OKAY);
				wr(ADDR_CTRL, 32'h4, RESP_OKAY);
				wait_mode(MDP_INACTIVE);
			end
		end
		wr(ADDR_CTRL, 32'h3, RESP_OKAY);
		wait_mode(MDP_ACTIVE);
		q.delete();
		@(posedge aclk);
		trip <= 1'b1;
		cdone <= 1'b1;
		@(posedge aclk);
		cdone <= 1'b0;
		@(negedge aclk);
		check("mode", {30'h0, MDP_ERROR}, {30'h0, mode});
		check("oe", 32'h0, {26'h0, gate_oe});
		repeat (6) @(negedge aclk);
		pri = 4'h0;
		n = 0;
		foreach (q[i]) if (q[i] != 2'h2 && n < 2) begin
			pri = {pri[1:0], q[i]};
			n++;
		end
		check("order", 32'h1, {28'h0, pri});
		wr(ADDR_CTRL, 32'h4, RESP_OKAY);
		check("mode", {30'h0, MDP_ERROR}, {30'h0, mode});
		rd(ADDR_FAULT, 32'h1f, 32'h10, RESP_OKAY);
		@(posedge aclk);
		trip <= 1'b0;
		wr(ADDR_CTRL, 32'h4, RESP_OKAY);
		wait_mode(MDP_INACTIVE);
		rd(ADDR_FAULT, 32'h1f, 32'h0, RESP_OKAY);
		@(posedge aclk);
		spin <= 1'b0;
		repeat (60) @(negedge aclk);
		rd(ADDR_HALL, 32'h7, {29'h0, hall}, RESP_OKAY);
		check("hall chg", 32'h1, 32'(hall_seen > 0));
		check("ticks", 32'h1, 32'(ticks > 0));
		close_out();
	end
endmodule : testbench
`default_nettype wire
